// ===== bcc_flow.sv
// bcc_flow: next-pc computation for jumps, dispatch and calls
// holds the pc register, the flag and bit tests, the dispatch displacement
// and the push side of the return stack
// assumes: decoder supplies op and operands for one cycle per instruction
// assumes: pc_follow already points past the whole instruction, second word included
// assumes: alias condition forms arrive upstream as flag_sel and want_state
// assumes: returns and interrupts pop the stack through ret_pop
// assumes: one clock, asynchronous active-low reset
// limitation: a call on a full stack is only refused and flagged; the program
// then runs on from pc_follow, so firmware must keep nesting within the depth
// How it works
// - short immediate jump adds sign-extended offset
// - short register jump adds sign-extended register
// - long jump loads absolute or index value
// - conditional relative jump only when flag matches
// - selector picks alu or link status flag
// - condition alias decodes as flag conditional jump
// - each condition maps to flag and state
// - long conditional jump tests one register bit
// - dispatch rotates copy, source untouched
// - dispatch clears lowest displacement bit
// - dispatch displacement signed, added to pc
// - dispatch also clears top m bits
// - short relative and long absolute calls
// - call pushes pc, gate, flags, bank
// - return stack twelve entries deep
`timescale 1ns/1ps
module bcc_flow
    import bcc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  exec,          // one-cycle instruction strobe
    input  wire bcc_op_t               op,            // operation to run
    input  wire logic [BCC_PC_W-1:0]   pc_follow,     // address after this instruction
    input  wire logic [7:0]            imm_off,       // relative offset operand
    input  wire logic [7:0]            src_val,       // source register value
    input  wire logic [BCC_PC_W-1:0]   abs_target,    // 16-bit absolute operand
    input  wire logic [BCC_PC_W-1:0]   index_val,     // index register
    input  wire logic [2:0]            flag_sel,      // flag selector
    input  wire logic                  want_state,    // required flag or bit state
    input  wire logic [2:0]            bit_pos,       // bit position for long test
    input  wire logic [2:0]            rot_count,     // dispatch rotate count
    input  wire logic [2:0]            mask_count,    // dispatch top bits cleared
    input  wire logic [3:0]            alu_flag_word, // z c v n
    input  wire logic [3:0]            link_status_word,
    input  wire logic                  global_irq_gate,
    input  wire logic [BCC_BANK_W-1:0] bank_sel,      // active register banks
    input  wire logic                  ret_pop,       // pop from return logic
    output logic [BCC_PC_W-1:0]        pc_out,        // registered program counter
    output logic                       branch_taken,  // registered, last op redirected
    output logic                       stack_overflow,// sticky, push refused when full
    output logic [BCC_SP_W-1:0]        stack_depth,   // entries in use
    output logic [BCC_ENTRY_W-1:0]     stack_top      // registered top entry
);
    // ========================================
    // timing
    // an op is taken at the rising edge where exec is high; pc_out, branch_taken,
    // stack_depth and stack_top show its result from that same edge on.
    // branch_taken stands for one cycle, pc_out until the next exec.
    // every target is worked out combinationally from the operands of the
    // launching cycle, so one op per cycle goes through with no stall; the price
    // is a 16-bit adder path from pc_follow into the pc register.
    // a push and a pop in one cycle: the push wins and the pop is lost; with the stack full the push is refused and the pop goes through.

    // ========================================
    // state and wires
    bcc_state_t          st_reg, st_next;
    bcc_stack_if         sif ();
    logic                flag_bit;   // selected flag
    logic                reg_bit;    // selected register bit
    logic [7:0]          rot_copy;   // rotated copy of source
    logic [7:0]          top_mask;   // clears top m bits
    logic [7:0]          disp;       // dispatch displacement
    logic [BCC_PC_W-1:0] rel_imm;    // pc + immediate
    logic [BCC_PC_W-1:0] rel_reg;    // pc + register
    logic [BCC_PC_W-1:0] rel_disp;   // pc + dispatch
    logic                is_call;    // op is one of the two calls

    // ========================================
    // flag selector decode; alias forms arrive as the same code and state
    // codes 0 to 3 read the alu flag word, 4 to 7 the link status word
    // all eight codes are legal, so the case needs no default
    always_comb begin
        unique case (flag_sel)
            BCC_F_ZERO:  flag_bit = alu_flag_word[BCC_ALU_Z];
            BCC_F_CARRY: flag_bit = alu_flag_word[BCC_ALU_C];
            BCC_F_OVF:   flag_bit = alu_flag_word[BCC_ALU_V];
            BCC_F_NEG:   flag_bit = alu_flag_word[BCC_ALU_N];
            BCC_F_RXB:   flag_bit = link_status_word[BCC_LNK_RXB];
            BCC_F_RXF:   flag_bit = link_status_word[BCC_LNK_RXF];
            BCC_F_RXW:   flag_bit = link_status_word[BCC_LNK_RXW];
            BCC_F_TXQ:   flag_bit = link_status_word[BCC_LNK_TXQ];
        endcase
    end

    // register bit test for the long conditional form
    // the decoder places the selected register on src_val
    assign reg_bit = src_val[bit_pos];

    // ========================================
    // dispatch: rotate a copy, mask top m bits and bit 0
    // the doubled copy lets a plain shift act as a rotate; src_val is never written
    // the result is even and lies between -128 and +126
    always_comb begin
        rot_copy = 8'((({src_val, src_val}) >> rot_count));
        top_mask = 8'(8'hFF >> mask_count);
        disp     = rot_copy & top_mask & 8'hFE;
    end

    // relative targets, sign extended; pc_follow is already past the jump
    // sums wrap at 16 bits, like the program space
    assign rel_imm  = pc_follow + {{8{imm_off[7]}}, imm_off};
    assign rel_reg  = pc_follow + {{8{src_val[7]}}, src_val};
    assign rel_disp = pc_follow + {{8{disp[7]}}, disp};

    // ========================================
    // call push: pc, gate, z c n v, bank
    // the entry is built every cycle; the stack only stores it on a push
    assign is_call  = (op == BCC_OP_CALL_REL) || (op == BCC_OP_CALL_ABS);
    assign sif.push = exec && is_call;
    assign sif.data = {pc_follow, global_irq_gate,
                       alu_flag_word[BCC_ALU_Z], alu_flag_word[BCC_ALU_C],
                       alu_flag_word[BCC_ALU_N], alu_flag_word[BCC_ALU_V],
                       bank_sel};

    // return stack; its top entry comes out of a register
    bcc_ret_stack #(
        .DEPTH (BCC_STACK_DEP)
    ) u_stack (
        .clock    (clock),
        .rst_n    (rst_n),
        .pop_req  (ret_pop),
        .top_data (stack_top),
        .sif      (sif.mem)
    );

    // ========================================
    // next pc
    always_comb begin
        st_next       = st_reg;
        st_next.taken = 1'b0;
        if (exec) begin
            st_next.pc = pc_follow; // fall through, past any second word
            unique case (op)
                BCC_OP_NONE: begin
                    // sequential step, nothing redirected
                end
                BCC_OP_SHORT_IMM: begin
                    // short_branch, offset from the instruction
                    st_next.pc    = rel_imm;
                    st_next.taken = 1'b1;
                end
                BCC_OP_SHORT_REG: begin
                    // short_branch, offset from a register
                    st_next.pc    = rel_reg;
                    st_next.taken = 1'b1;
                end
                BCC_OP_LONG_ABS: begin
                    // long_branch to the absolute operand
                    st_next.pc    = abs_target;
                    st_next.taken = 1'b1;
                end
                BCC_OP_LONG_IDX: begin
                    // long_branch through the index register
                    st_next.pc    = index_val;
                    st_next.taken = 1'b1;
                end
                BCC_OP_COND_REL: begin
                    // a miss keeps the fall-through pc set above
                    if (flag_bit == want_state) begin
                        st_next.pc    = rel_imm;
                        st_next.taken = 1'b1;
                    end
                end
                BCC_OP_COND_LONG: begin
                    // on a miss pc_follow itself skips the second word
                    if (reg_bit == want_state) begin
                        st_next.pc    = abs_target;
                        st_next.taken = 1'b1;
                    end
                end
                BCC_OP_DISPATCH: begin
                    // always taken; the table decides where it lands
                    st_next.pc    = rel_disp;
                    st_next.taken = 1'b1;
                end
                BCC_OP_CALL_REL, BCC_OP_CALL_ABS: begin
                    // a call with the stack full is refused and flagged
                    if (sif.full) begin
                        st_next.mode = BCC_ST_OVERFLOW;
                        st_next.ovf  = 1'b1;
                    end else begin
                        // push and redirect in the same cycle
                        st_next.pc    = (op == BCC_OP_CALL_REL) ? rel_imm : abs_target;
                        st_next.taken = 1'b1;
                    end
                end
                default: begin
                    // spare op codes act as a sequential step
                end
            endcase
        end
    end

    // state register
    // asynchronous reset loads constants only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{pc: BCC_PC_RST, mode: BCC_ST_RUN, taken: 1'b0, ovf: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // outputs, all straight from registers
    assign pc_out         = st_reg.pc;
    assign branch_taken   = st_reg.taken;
    assign stack_overflow = st_reg.ovf;
    assign stack_depth    = sif.depth;
endmodule

// ===== bcc_flow_props.sv
// bcc_flow_props: port-level checks of the program-flow block
// assumes: bound to bcc_flow, one clock, asynchronous active-low reset
`timescale 1ns/1ps
module bcc_flow_props
    import bcc_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  exec,
    input wire bcc_op_t               op,
    input wire logic [BCC_PC_W-1:0]   pc_follow,
    input wire logic [7:0]            imm_off,
    input wire logic [7:0]            src_val,
    input wire logic [BCC_PC_W-1:0]   abs_target,
    input wire logic [BCC_PC_W-1:0]   index_val,
    input wire logic [2:0]            flag_sel,
    input wire logic                  want_state,
    input wire logic [2:0]            bit_pos,
    input wire logic [2:0]            rot_count,
    input wire logic [2:0]            mask_count,
    input wire logic [3:0]            alu_flag_word,
    input wire logic [3:0]            link_status_word,
    input wire logic                  global_irq_gate,
    input wire logic [BCC_BANK_W-1:0] bank_sel,
    input wire logic [BCC_PC_W-1:0]   pc_out,
    input wire logic                  branch_taken,
    input wire logic                  stack_overflow,
    input wire logic [BCC_SP_W-1:0]   stack_depth,
    input wire logic [BCC_ENTRY_W-1:0] stack_top
);
    // ========================================
    // expected values from the inputs of the launching cycle
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic [15:0] rot2    = {src_val, src_val} >> rot_count; // low byte is the rotated copy
    wire logic [7:0]  disp    = rot2[7:0] & (8'hFF >> mask_count) & 8'hFE;
    wire logic [7:0]  flags   = {link_status_word, alu_flag_word}; // selector code is the index
    wire logic [15:0] tgt_imm = pc_follow + {{8{imm_off[7]}}, imm_off};
    wire logic [15:0] tgt_reg = pc_follow + {{8{src_val[7]}}, src_val};
    wire logic [15:0] tgt_dsp = pc_follow + {{8{disp[7]}}, disp};
    wire logic [15:0] tgt_cal = (op == BCC_OP_CALL_REL) ? tgt_imm : abs_target;
    wire logic        call    = exec && (op == BCC_OP_CALL_REL || op == BCC_OP_CALL_ABS);
    wire logic [24:0] entry   = {pc_follow, global_irq_gate, alu_flag_word[0], alu_flag_word[1],
                                 alu_flag_word[3], alu_flag_word[2], bank_sel};
    // ========================================
    // jumps
    property p_short_imm;
        exec && op == BCC_OP_SHORT_IMM |=> branch_taken && pc_out == $past(tgt_imm);
    endproperty
    a_short_imm: assert property (p_short_imm)
        else $error("short immediate jump target wrong");
    property p_short_reg;
        exec && op == BCC_OP_SHORT_REG |=> branch_taken && pc_out == $past(tgt_reg);
    endproperty
    a_short_reg: assert property (p_short_reg)
        else $error("short register jump target wrong");
    property p_long;
        exec && (op == BCC_OP_LONG_ABS || op == BCC_OP_LONG_IDX) |=> branch_taken &&
            pc_out == ($past(op == BCC_OP_LONG_ABS) ? $past(abs_target) : $past(index_val));
    endproperty
    a_long: assert property (p_long)
        else $error("long jump target wrong");
    property p_cond_rel;
        exec && op == BCC_OP_COND_REL |=> branch_taken == ($past(flags[flag_sel]) ==
            $past(want_state)) && pc_out == (branch_taken ? $past(tgt_imm) : $past(pc_follow));
    endproperty
    a_cond_rel: assert property (p_cond_rel)
        else $error("conditional relative jump wrong");
    property p_cond_long;
        exec && op == BCC_OP_COND_LONG |=> pc_out == (($past(src_val[bit_pos]) ==
            $past(want_state)) ? $past(abs_target) : $past(pc_follow));
    endproperty
    a_cond_long: assert property (p_cond_long)
        else $error("bit conditional long jump wrong");
    property p_dispatch;
        exec && op == BCC_OP_DISPATCH |=> branch_taken && pc_out == $past(tgt_dsp);
    endproperty
    a_dispatch: assert property (p_dispatch)
        else $error("dispatch jump target wrong");
    // ========================================
    // calls and the return stack
    property p_push;
        call && stack_depth < 4'hC |=> stack_depth == $past(stack_depth) + 4'h1 &&
            stack_top == $past(entry) && pc_out == $past(tgt_cal);
    endproperty
    a_push: assert property (p_push)
        else $error("call push or target wrong");
    property p_full;
        call && stack_depth == 4'hC |=> stack_overflow && stack_depth == 4'hC &&
            !branch_taken && pc_out == $past(pc_follow);
    endproperty
    a_full: assert property (p_full)
        else $error("call on full stack not refused");
endmodule
bind bcc_flow bcc_flow_props u_props (
    .clock            (clock),
    .rst_n            (rst_n),
    .exec             (exec),
    .op               (op),
    .pc_follow        (pc_follow),
    .imm_off          (imm_off),
    .src_val          (src_val),
    .abs_target       (abs_target),
    .index_val        (index_val),
    .flag_sel         (flag_sel),
    .want_state       (want_state),
    .bit_pos          (bit_pos),
    .rot_count        (rot_count),
    .mask_count       (mask_count),
    .alu_flag_word    (alu_flag_word),
    .link_status_word (link_status_word),
    .global_irq_gate  (global_irq_gate),
    .bank_sel         (bank_sel),
    .pc_out           (pc_out),
    .branch_taken     (branch_taken),
    .stack_overflow   (stack_overflow),
    .stack_depth      (stack_depth),
    .stack_top        (stack_top)
);

// ===== bcc_pkg.sv
// bcc_pkg: shared constants and types of the program-flow block
// assumes: included before every other file of the block
package bcc_pkg;
    // ========================================
    // widths
    localparam int BCC_PC_W      = 16;
    localparam int BCC_STACK_DEP = 12;
    localparam int BCC_SP_W      = 4;
    // ========================================
    // stack entry layout: pc, gate, z c n v, bank
    localparam int BCC_BANK_W    = 4;
    localparam int BCC_ENTRY_W   = BCC_PC_W + 1 + 4 + BCC_BANK_W;
    // ========================================
    // flag selector codes
    localparam logic [2:0] BCC_F_ZERO  = 3'h0;
    localparam logic [2:0] BCC_F_CARRY = 3'h1;
    localparam logic [2:0] BCC_F_OVF   = 3'h2;
    localparam logic [2:0] BCC_F_NEG   = 3'h3;
    localparam logic [2:0] BCC_F_RXB   = 3'h4;
    localparam logic [2:0] BCC_F_RXF   = 3'h5;
    localparam logic [2:0] BCC_F_RXW   = 3'h6;
    localparam logic [2:0] BCC_F_TXQ   = 3'h7;
    // ========================================
    // alu flag word bit positions
    localparam int BCC_ALU_Z = 0;
    localparam int BCC_ALU_C = 1;
    localparam int BCC_ALU_V = 2;
    localparam int BCC_ALU_N = 3;
    // link status word bit positions
    localparam int BCC_LNK_RXB = 0;
    localparam int BCC_LNK_RXF = 1;
    localparam int BCC_LNK_RXW = 2;
    localparam int BCC_LNK_TXQ = 3;
    // ========================================
    // reset values
    localparam logic [15:0] BCC_PC_RST = 16'h0000;
    localparam logic [3:0]  BCC_SP_RST = 4'h0;
    // ========================================
    // program-flow operations
    typedef enum logic [3:0] {
        BCC_OP_NONE,      // sequential, pc taken from pc_follow
        BCC_OP_SHORT_IMM, // short_branch by immediate
        BCC_OP_SHORT_REG, // short_branch by register
        BCC_OP_LONG_ABS,  // long_branch absolute
        BCC_OP_LONG_IDX,  // long_branch by index register
        BCC_OP_COND_REL,  // flag conditional / condition_alias_branch
        BCC_OP_COND_LONG, // bit conditional long_branch
        BCC_OP_DISPATCH,  // field_dispatch_branch
        BCC_OP_CALL_REL,  // short call
        BCC_OP_CALL_ABS   // long_subroutine_entry
    } bcc_op_t;
    // state of the top module
    typedef enum logic [1:0] {
        BCC_ST_RUN,
        BCC_ST_OVERFLOW
    } bcc_mode_t;
    typedef struct packed {
        logic [BCC_PC_W-1:0] pc;
        bcc_mode_t           mode;
        logic                taken;
        logic                ovf;
    } bcc_state_t;
endpackage

// ===== bcc_ret_stack.sv
// bcc_ret_stack: twelve-entry return stack, push and pop sides
// assumes: pops come from return logic elsewhere via pop_req
`timescale 1ns/1ps
module bcc_ret_stack
    import bcc_pkg::*;
#(
    parameter int DEPTH = BCC_STACK_DEP
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   pop_req,
    output logic [BCC_ENTRY_W-1:0]      top_data,
    bcc_stack_if.mem                    sif
);
    // ========================================
    // state
    typedef struct packed {
        logic [BCC_SP_W-1:0]    sp;
        logic [BCC_ENTRY_W-1:0] top;
    } bcc_stk_state_t;
    bcc_stk_state_t                st_reg, st_next;
    logic [BCC_ENTRY_W-1:0]        mem [DEPTH]; // entries, no reset needed
    logic [BCC_SP_W-1:0]           rd_idx;

    // entry below the pointer after a pop
    always_comb begin
        rd_idx = st_reg.sp - 4'h2;
    end

    // ========================================
    // pointer and top-entry register
    always_comb begin
        st_next = st_reg;
        if (sif.push && !sif.full) begin
            st_next.sp  = st_reg.sp + 4'h1;
            st_next.top = sif.data;
        end else if (pop_req && st_reg.sp != BCC_SP_RST) begin
            // read data kept in a register, not straight from memory
            st_next.sp  = st_reg.sp - 4'h1;
            st_next.top = (st_reg.sp > 4'h1) ? mem[rd_idx] : '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // memory write; a push when full is dropped, never overwrites
    always_ff @(posedge clock) begin
        if (sif.push && !sif.full) begin
            mem[st_reg.sp] <= sif.data;
        end
    end

    assign sif.full  = (st_reg.sp == BCC_SP_W'(DEPTH));
    assign sif.depth = st_reg.sp;
    assign top_data  = st_reg.top;
endmodule

// ===== bcc_stack_if.sv
// bcc_stack_if: push port between the flow logic and the return stack
// assumes: one clock domain
`timescale 1ns/1ps
interface bcc_stack_if;
    import bcc_pkg::*;
    logic                   push;  // one-cycle push request
    logic [BCC_ENTRY_W-1:0] data;  // entry to store
    logic                   full;  // all twelve entries used
    logic [BCC_SP_W-1:0]    depth; // entries in use
    modport ctrl (output push, output data, input full, input depth);
    modport mem  (input push, input data, output full, output depth);
endinterface

// ===== test_branch_call_control.sv
// test_branch_call_control: directed self-checking bench of the program-flow block
// assumes: bcc_pkg, bcc_stack_if, bcc_ret_stack, bcc_flow and the checker compiled first
`timescale 1ns/1ps
module test_branch_call_control;
    import bcc_pkg::*;
    // ========================================
    // stimulus and observed signals
    logic        clock = 1'b0, rst_n = 1'b0, exec = 1'b0, want = 1'b0, gate = 1'b0, pop = 1'b0;
    bcc_op_t     op = BCC_OP_NONE;
    logic [15:0] pcf = 16'h0000, abst = 16'h0000, idx = 16'h0000, pc_out;
    logic [7:0]  imm = 8'h00, src = 8'h00;
    logic [2:0]  fsel = 3'h0, bpos = 3'h0, rot = 3'h0, msk = 3'h0;
    logic [3:0]  alu = 4'h0, lnk = 4'h0, bank = 4'h0, depth;
    logic        taken, ovf;
    logic [24:0] top;
    int          n_mismatch = 0, cmp_count = 0;
    always #5 clock = ~clock;
    bcc_flow dut (.clock(clock), .rst_n(rst_n), .exec(exec), .op(op), .pc_follow(pcf),
        .imm_off(imm), .src_val(src), .abs_target(abst), .index_val(idx), .flag_sel(fsel),
        .want_state(want), .bit_pos(bpos), .rot_count(rot), .mask_count(msk),
        .alu_flag_word(alu), .link_status_word(lnk), .global_irq_gate(gate), .bank_sel(bank),
        .ret_pop(pop), .pc_out(pc_out), .branch_taken(taken), .stack_overflow(ovf),
        .stack_depth(depth), .stack_top(top));
    // ========================================
    // shared tasks
    task automatic chk(input string what, input logic [24:0] exp, input logic [24:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // called at a rising edge: exec stands one cycle, results are read once they land
    task automatic step(input bcc_op_t o);
        op <= o;
        exec <= 1'b1;
        @(posedge clock);
        exec <= 1'b0;
        #1;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        chk("reset pc", 25'(16'h0000), 25'(pc_out));
        chk("reset top", 25'h000_0000, top);
        chk("reset flags", 25'h000_0000, 25'({taken, ovf, depth}));
        rst_n <= 1'b1;
    endtask
    // both sign extremes, immediate and register sources kept apart
    task automatic t_short();
        logic [7:0]  offs [4] = '{8'hFE, 8'h7F, 8'h80, 8'h01};
        logic [15:0] exp_pc;
        foreach (offs[i]) begin
            @(posedge clock);
            pcf <= 16'h0010;
            imm <= i[0] ? ~offs[i] : offs[i];
            src <= i[0] ? offs[i] : ~offs[i];
            step(i[0] ? BCC_OP_SHORT_REG : BCC_OP_SHORT_IMM);
            // the target wraps at 16 bits like the pc itself
            exp_pc = 16'h0010 + {{8{offs[i][7]}}, offs[i]};
            chk("short pc", 25'(exp_pc), 25'(pc_out));
        end
    endtask
    task automatic t_long();
        @(posedge clock);
        abst <= 16'hFFFF;
        idx <= 16'h8001;
        step(BCC_OP_LONG_ABS);
        chk("long abs pc", 25'(16'hFFFF), 25'(pc_out));
        @(posedge clock);
        step(BCC_OP_LONG_IDX);
        chk("long idx pc", 25'(16'h8001), 25'(pc_out));
        @(posedge clock);
        pcf <= 16'h1234;
        step(BCC_OP_NONE);
        chk("plain step pc", 25'(16'h1234), 25'(pc_out));
        chk("plain step taken", 25'(1'b0), 25'(taken));
    endtask
    // only the selected flag is set, so a wrong selector reads zero
    task automatic t_cond();
        for (int k = 0; k < 16; k++) begin
            @(posedge clock);
            {lnk, alu} <= 8'h01 << k[3:1];
            fsel <= k[3:1];
            want <= k[0];
            pcf <= 16'h0200;
            imm <= 8'hF0;
            step(BCC_OP_COND_REL);
            chk("cond taken", 25'(k[0]), 25'(taken));
            chk("cond pc", k[0] ? 25'(16'h01F0) : 25'(16'h0200), 25'(pc_out));
        end
    endtask
    task automatic t_clong();
        for (int k = 0; k < 16; k++) begin
            @(posedge clock);
            src <= 8'h01 << k[3:1];
            bpos <= k[3:1];
            want <= k[0];
            abst <= 16'hA5C3;
            pcf <= 16'h0302;
            step(BCC_OP_COND_LONG);
            chk("bit jump pc", k[0] ? 25'(16'hA5C3) : 25'(16'h0302), 25'(pc_out));
        end
    endtask
    // entries: source, rotate, top bits cleared, displacement
    task automatic t_dispatch();
        logic [21:0] tab [3] = '{{8'hFF, 3'h1, 3'h4, 8'h0E}, {8'h01, 3'h1, 3'h0, 8'h80},
                                 {8'h03, 3'h7, 3'h1, 8'h06}};
        logic [15:0] exp_pc;
        foreach (tab[i]) begin
            @(posedge clock);
            {src, rot, msk} <= tab[i][21:8];
            pcf <= 16'h0400;
            step(BCC_OP_DISPATCH);
            exp_pc = 16'h0400 + {{8{tab[i][7]}}, tab[i][7:0]};
            chk("dispatch pc", 25'(exp_pc), 25'(pc_out));
        end
    endtask
    // twelve nested calls, one refused, then a return pops
    task automatic t_calls();
        for (int k = 0; k < 13; k++) begin
            @(posedge clock);
            pcf <= 16'h2000 + 16'(k);
            abst <= 16'h3000 + 16'(k);
            imm <= 8'h10;
            gate <= k[0];
            alu <= k[3:0];
            bank <= ~k[3:0];
            step(k[1] ? BCC_OP_CALL_ABS : BCC_OP_CALL_REL);
            chk("call depth", 25'(k < 12 ? k + 1 : 12), 25'(depth));
            chk("call refused", 25'(k == 12), 25'(ovf));
            if (k < 12) begin
                chk("call pc", 25'(k[1] ? 16'h3000 + 16'(k) : 16'h2010 + 16'(k)), 25'(pc_out));
                chk("call entry", {16'h2000 + 16'(k), k[0], k[0], k[1], k[3], k[2], ~k[3:0]}, top);
            end
        end
        @(posedge clock);
        pop <= 1'b1;
        @(posedge clock);
        pop <= 1'b0;
        #1;
        chk("pop depth", 25'(11), 25'(depth));
        // the entry of the eleventh call is on top again
        chk("pop top", {16'h200A, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h5}, top);
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        do_reset();
        t_short();
        t_long();
        t_cond();
        t_clong();
        t_dispatch();
        t_calls();
        do_reset();
        end_of_test();
    end
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule
